/* rtl/ipr_pkg.sv */
// Constants and types shared by the interrupt priority register block.
// Assumes a 32-bit Avalon-MM slave port with byte addressing.
package ipr_pkg;

    // Bus geometry
    localparam int          IPR_ADDR_W      = 4;
    localparam int          IPR_DATA_W      = 32;
    localparam int          IPR_BE_W        = 4;

    // Register byte offsets
    localparam logic [3:0]  IPR_OFS_PRIO    = 4'h0;  // Priority control register
    localparam logic [3:0]  IPR_OFS_STAT    = 4'h4;  // Pending and top level status

    // Priority register layout
    localparam int          IPR_REG_W       = 16;
    localparam int          IPR_NUM_SRC     = 4;
    localparam int          IPR_LVL_W       = 3;
    localparam int          IPR_FLD_STRIDE  = 4;
    localparam int          IPR_DMA3_LSB    = 0;
    localparam int          IPR_CAP3_LSB    = 4;
    localparam int          IPR_CAP4_LSB    = 8;
    localparam int          IPR_CAP5_LSB    = 12;
    localparam logic [15:0] IPR_IMPL_MASK   = 16'h7777;
    localparam logic [15:0] IPR_PRIO_RESET  = 16'h4444;

    // Level encodings
    localparam logic [2:0]  IPR_LVL_OFF     = 3'h0;
    localparam logic [2:0]  IPR_LVL_MIN     = 3'h1;
    localparam logic [2:0]  IPR_LVL_MAX     = 3'h7;

    // Status register layout
    localparam int          IPR_STAT_PEND_LSB = 0;
    localparam int          IPR_STAT_TOP_LSB  = 4;

    // Field values as named per source
    typedef struct packed {
        logic       rsv15;
        logic [2:0] capture5_irq_level;
        logic       rsv11;
        logic [2:0] capture4_irq_level;
        logic       rsv7;
        logic [2:0] capture3_irq_level;
        logic       rsv3;
        logic [2:0] dma_ch3_irq_level;
    } ipr_levels_t;

    // Register write command from the bus slave
    typedef struct packed {
        logic        strobe;
        logic [3:0]  addr;
        logic [31:0] data;
        logic [3:0]  be;
    } ipr_wr_t;

    // Arbitration result
    typedef struct packed {
        logic [3:0] pending;
        logic [2:0] top_level;
    } ipr_arb_t;

endpackage : ipr_pkg

/* rtl/ipr_avs_slave.sv */
// Avalon-MM slave handshake for the priority register block.
// Assumes the master holds its request until it samples waitrequest low.
`timescale 1ns/100ps
module ipr_avs_slave
    import ipr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] rd_word,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output ipr_wr_t          wr_cmd
);

    // Handshake state
    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
    } ipr_slv_t;

    ipr_slv_t slv_reg;   // Registered state
    ipr_slv_t slv_next;  // Next state

    // First cycle of a request drops waitrequest; the next completes it
    always_comb begin
        slv_next      = slv_reg;
        wr_cmd.strobe = 1'b0;
        wr_cmd.addr   = avs_address;
        wr_cmd.data   = avs_writedata;
        wr_cmd.be     = avs_byteenable;
        if (!slv_reg.waitreq) begin
            // Completing edge: write lands, waitrequest rises again
            slv_next.waitreq = 1'b1;
            wr_cmd.strobe    = avs_write;
        end else if (avs_read || avs_write) begin
            // Request seen: capture read data, release next cycle
            slv_next.waitreq = 1'b0;
            slv_next.rdata   = avs_read ? rd_word : 32'h0000_0000;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            slv_reg <= '{waitreq: 1'b1, rdata: 32'h0000_0000};
        end else if (clk_en) begin
            slv_reg <= slv_next;
        end
    end

    // Waitrequest is forced high while frozen, so no access completes on a
    // frozen edge and a held write is never lost
    assign avs_readdata    = slv_reg.rdata;
    assign avs_waitrequest = slv_reg.waitreq || !clk_en;

endmodule : ipr_avs_slave

/* rtl/ipr_level_arb.sv */
// Gates each source by its priority field and finds the highest level.
// Assumes source requests come from logic on the same clock.
`timescale 1ns/100ps
module ipr_level_arb
    import ipr_pkg::*;
#(
    parameter int NUM_SRC = IPR_NUM_SRC
)
(
    input  wire logic [15:0]        prio,
    input  wire logic [NUM_SRC-1:0] src_irq,
    output ipr_arb_t                arb
);

    logic [2:0]         lvl [NUM_SRC];  // Field per source
    logic [NUM_SRC-1:0] pend;           // Enabled and requesting

    // Per source: a zero field never presents a request
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        assign lvl[i]  = prio[IPR_FLD_STRIDE*i +: IPR_LVL_W];
        assign pend[i] = src_irq[i] && (lvl[i] != IPR_LVL_OFF);
    end

    // Highest numeric field wins; 7 is top, 1 is bottom
    always_comb begin
        arb.pending   = pend;
        arb.top_level = IPR_LVL_OFF;
        for (int k = 0; k < NUM_SRC; k++) begin
            if (pend[k] && (lvl[k] > arb.top_level)) begin
                arb.top_level = lvl[k];
            end
        end
    end

endmodule : ipr_level_arb

/* rtl/ipr_top.sv */
// Interrupt priority control register 9 with its arbitration outputs.
// Assumes an Avalon-MM master on mclk and same-clock source requests.
// Clock enable is driven from mclk logic; low holds every register.
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module ipr_top
    import ipr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [3:0]  src_irq,
    output ipr_levels_t      irq_levels,
    output logic [3:0]       irq_pending,
    output logic [2:0]       irq_top_level,
    output logic             irq_any
);

    // Whole block state
    // Priority word plus the registered arbitration result
    typedef struct packed {
        logic [15:0] prio;
        logic [3:0]  pending;
        logic [2:0]  top_level;
        logic        any;
    } ipr_state_t;

    ipr_state_t st_reg;   // Registered state
    ipr_state_t st_next;  // Next state
    ipr_wr_t    wr_cmd;   // Write from the bus
    ipr_arb_t   arb;      // Gated requests and top level
    logic [31:0] rd_word; // Read mux result
    logic [15:0] wr_mask; // Bits a write may change

    // Bus slave
    ipr_avs_slave u_slave (
        .mclk            (mclk),
        .sys_rst         (sys_rst),
        .clk_en          (clk_en),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .rd_word         (rd_word),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .wr_cmd          (wr_cmd)
    );

    // Source gating and level arbitration
    ipr_level_arb #(
        .NUM_SRC (IPR_NUM_SRC)
    ) u_arb (
        .prio    (st_reg.prio),
        .src_irq (src_irq),
        .arb     (arb)
    );

    // Read mux: priority register, status, zero elsewhere
    // The slave captures this word on the edge that accepts a read
    always_comb begin
        rd_word = 32'h0000_0000;
        case (avs_address)
            IPR_OFS_PRIO: begin
                rd_word[15:0] = st_reg.prio & IPR_IMPL_MASK;
            end
            IPR_OFS_STAT: begin
                rd_word[IPR_STAT_PEND_LSB +: 4] = st_reg.pending;
                rd_word[IPR_STAT_TOP_LSB +: 3]  = st_reg.top_level;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // Next state: byte-lane merge on write, arbitration capture
    // A write only lands on the completing edge of its access
    always_comb begin
        st_next = st_reg;
        wr_mask = {{8{wr_cmd.be[1]}}, {8{wr_cmd.be[0]}}} & IPR_IMPL_MASK;
        if (wr_cmd.strobe && (wr_cmd.addr == IPR_OFS_PRIO)) begin
            // Only implemented bits in enabled lanes change
            st_next.prio = (st_reg.prio & ~wr_mask)
                         | (wr_cmd.data[15:0] & wr_mask);
        end
        st_next.pending   = arb.pending;
        st_next.top_level = arb.top_level;
        st_next.any       = |arb.pending;
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '{prio: IPR_PRIO_RESET,
                        pending: 4'h0,
                        top_level: 3'h0,
                        any: 1'b0};
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state
    assign irq_levels    = ipr_levels_t'(st_reg.prio);
    assign irq_pending   = st_reg.pending;
    assign irq_top_level = st_reg.top_level;
    assign irq_any       = st_reg.any;

    // Checks: bus handshake, field storage and lanes, source gating,
    // level ordering, clock enable freeze and reset values. All run on
    // mclk and are silenced while reset is high, except the reset checks.
    // Helper nets below feed the checks only.

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Full write of the priority word lands on the completing edge
    a_field_write: assert property (
        clk_en && avs_write && !avs_waitrequest
        && (avs_address == IPR_OFS_PRIO) && (avs_byteenable[1:0] == 2'h3)
        |=> st_reg.prio == ($past(avs_writedata[15:0]) & IPR_IMPL_MASK))
        else $error("priority write not stored");

    // Unwritten lanes keep their value
    a_lane_hold: assert property (
        clk_en && avs_write && !avs_waitrequest
        && (avs_address == IPR_OFS_PRIO) && (avs_byteenable[1:0] == 2'h1)
        |=> st_reg.prio[15:8] == $past(st_reg.prio[15:8]))
        else $error("disabled byte lane changed");

    // Reserved bits never set in storage
    a_reserved_zero: assert property (
        (st_reg.prio & ~IPR_IMPL_MASK) == 16'h0000)
        else $error("reserved priority bit set");

    // Read of the priority word returns stored value with zero holes
    a_read_word: assert property (
        clk_en && avs_read && avs_waitrequest
        && (avs_address == IPR_OFS_PRIO)
        |=> (!avs_waitrequest || !clk_en)
            && (avs_readdata == {16'h0000, $past(st_reg.prio) & IPR_IMPL_MASK}))
        else $error("priority read data wrong");

    // Source 0 requesting at field 7 sets the top level to 7
    a_top_highest: assert property (
        clk_en && src_irq[0] && (st_reg.prio[2:0] == IPR_LVL_MAX)
        |=> irq_top_level == IPR_LVL_MAX)
        else $error("level seven not top");

    // Any pending request gives a level of at least one
    a_level_floor: assert property (
        irq_any |-> (irq_top_level >= IPR_LVL_MIN)
                    && (irq_pending != 4'h0))
        else $error("pending with level zero");

    // Top level follows the higher of two requesting fields
    a_level_order: assert property (
        clk_en && (src_irq == 4'h3)
        && (st_reg.prio[2:0] != IPR_LVL_OFF)
        && (st_reg.prio[6:4] > st_reg.prio[2:0])
        |=> irq_top_level == $past(st_reg.prio[6:4]))
        else $error("top level not the highest");

    // Nonzero priority field per source, for the checks
    logic [3:0] fld_on;  // Source enabled by its field

    // Disabled sources never appear pending
    for (genvar g = 0; g < IPR_NUM_SRC; g++) begin : g_chk
        a_disabled_quiet: assert property (
            clk_en
            && (st_reg.prio[IPR_FLD_STRIDE*g +: IPR_LVL_W] == IPR_LVL_OFF)
            |=> !irq_pending[g])
            else $error("disabled source presented");

        // Field enabled flag for this source
        assign fld_on[g] = (st_reg.prio[IPR_FLD_STRIDE*g +: IPR_LVL_W] != IPR_LVL_OFF);

        // Top level never below the field of a requesting enabled source
        a_top_covers: assert property (
            clk_en && src_irq[g] && fld_on[g]
            |=> irq_top_level >= $past(st_reg.prio[IPR_FLD_STRIDE*g +: IPR_LVL_W]))
            else $error("top level below a pending field");

        // A lone requesting source sets the top level to its own field
        a_single_level: assert property (
            clk_en && ((src_irq & fld_on) == 4'(1 << g))
            |=> irq_top_level == $past(st_reg.prio[IPR_FLD_STRIDE*g +: IPR_LVL_W]))
            else $error("lone source level not reported");
    end

    // Each pending bit is its request gated by a nonzero field
    a_pend_gate: assert property (
        clk_en |=> irq_pending == $past(src_irq & fld_on))
        else $error("pending not the gated requests");

    // Any flag mirrors the pending word
    a_any_mirror: assert property (
        irq_any == (irq_pending != 4'h0))
        else $error("any flag disagrees with pending");

    // Level zero exactly when nothing is pending
    a_top_zero: assert property (
        (irq_top_level == IPR_LVL_OFF) == (irq_pending == 4'h0))
        else $error("top level zero disagrees with pending");

    // Waitrequest drops for a single cycle per access
    a_wait_pulse: assert property (
        clk_en && !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");

    // An accepted request is answered on the next edge
    a_wait_answer: assert property (
        clk_en && (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest || !clk_en)
        else $error("request not answered");

    // No request, no answer
    a_idle_stall: assert property (
        !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest dropped without a request");

    // Read data only moves when a request is accepted
    a_rdata_hold: assert property (
        clk_en && !((avs_read || avs_write) && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved without a request");

    // The priority word only moves on a completed write to it
    a_prio_stable: assert property (
        clk_en
        && !(avs_write && !avs_waitrequest && (avs_address == IPR_OFS_PRIO))
        |=> $stable(st_reg.prio))
        else $error("priority word moved without a write");

    // Writes outside the priority word leave it alone
    a_write_ignored: assert property (
        clk_en && avs_write && !avs_waitrequest
        && (avs_address != IPR_OFS_PRIO)
        |=> st_reg.prio == $past(st_reg.prio))
        else $error("write elsewhere changed priorities");

    // Lower lane keeps its value when only the upper lane is enabled
    a_low_lane: assert property (
        clk_en && avs_write && !avs_waitrequest
        && (avs_address == IPR_OFS_PRIO) && (avs_byteenable[1:0] == 2'h2)
        |=> st_reg.prio[7:0] == $past(st_reg.prio[7:0]))
        else $error("disabled low byte lane changed");

    // Lanes two and three alone change nothing
    a_lane_none: assert property (
        clk_en && avs_write && !avs_waitrequest
        && (avs_address == IPR_OFS_PRIO) && (avs_byteenable[1:0] == 2'h0)
        |=> st_reg.prio == $past(st_reg.prio))
        else $error("write with no low lanes changed priorities");

    // Status read returns pending bits and top level
    a_read_status: assert property (
        clk_en && avs_read && avs_waitrequest
        && (avs_address == IPR_OFS_STAT)
        |=> (!avs_waitrequest || !clk_en)
            && (avs_readdata[6:0] == {$past(st_reg.top_level), $past(st_reg.pending)})
            && (avs_readdata[31:7] == 25'h000_0000))
        else $error("status read data wrong");

    // Unmapped reads return zero
    a_read_unmapped: assert property (
        clk_en && avs_read && avs_waitrequest
        && (avs_address != IPR_OFS_PRIO) && (avs_address != IPR_OFS_STAT)
        |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // Clock enable low freezes every register of the block
    a_freeze_hold: assert property (
        !clk_en |=> (st_reg == $past(st_reg)) && (avs_readdata == $past(avs_readdata)))
        else $error("state moved while frozen");

    // Reset leaves the bus stalled and nothing pending
    a_reset_quiet: assert property (
        @(posedge mclk) disable iff (1'b0)
        $fell(sys_rst) |-> avs_waitrequest && !irq_any
                           && (irq_pending == 4'h0) && (irq_top_level == IPR_LVL_OFF))
        else $error("outputs not at reset values");

    // Reset leaves level four in every field
    a_reset_load: assert property (
        @(posedge mclk) disable iff (1'b0)
        $fell(sys_rst) |-> st_reg.prio == IPR_PRIO_RESET)
        else $error("reset value not loaded");

    // Main scenarios
    c_prio_write: cover property (
        clk_en && avs_write && !avs_waitrequest
        && (avs_address == IPR_OFS_PRIO));
    c_stat_read: cover property (
        clk_en && avs_read && !avs_waitrequest
        && (avs_address == IPR_OFS_STAT));
    c_masked_src: cover property (
        src_irq[3] && (st_reg.prio[14:12] == IPR_LVL_OFF));
    c_top_seven: cover property (irq_top_level == IPR_LVL_MAX);
    c_freeze_wait: cover property (!clk_en && avs_write);

endmodule : ipr_top

/* verification/tb_top.sv */
// Self-checking bench for the interrupt priority register block.
// Assumes ipr_pkg and ipr_top are compiled first; the bench acts as the Avalon master.
`timescale 1ns/100ps
module tb_top;
    import ipr_pkg::*;

    logic        mclk            = 1'b0;  // 40 MHz system clock
    logic        sys_rst         = 1'b1;  // Asynchronous reset, active high
    logic        clk_en          = 1'b1;  // Clock enable, running
    logic [3:0]  avs_address     = 4'h0;  // Bus byte address
    logic        avs_read        = 1'b0;  // Bus read strobe
    logic        avs_write       = 1'b0;  // Bus write strobe
    logic [31:0] avs_writedata   = 32'h0; // Bus write data
    logic [3:0]  avs_byteenable  = 4'h0;  // Bus byte lanes
    logic [31:0] avs_readdata;            // Bus read data
    logic        avs_waitrequest;         // Bus stall
    logic [3:0]  src_irq         = 4'h0;  // Raw source requests
    ipr_levels_t irq_levels;              // Priority fields as held
    logic [3:0]  irq_pending;             // Enabled requesting sources
    logic [2:0]  irq_top_level;           // Highest pending level
    logic        irq_any;                 // Any source pending
    int          errors          = 0;     // Mismatch count
    int          n_tests         = 0;     // Comparison count
    logic [31:0] rd;                      // Last read word

    // Clock: invert every half period
    always #12.5 mclk = ~mclk;

    ipr_top DUT (
        .mclk            (mclk),
        .sys_rst         (sys_rst),
        .clk_en          (clk_en),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .src_irq         (src_irq),
        .irq_levels      (irq_levels),
        .irq_pending     (irq_pending),
        .irq_top_level   (irq_top_level),
        .irq_any         (irq_any)
    );

    // Prints the counts and the verdict, then stops
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // Compares a seen value against the expected one
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One bus access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge mclk);
        avs_read       <= ~wr;
        avs_write      <= wr;
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        // Waits as long as it takes; only the watchdog ends a hang
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // Writes the priority register, all four lanes enabled
    task automatic wr_prio(input logic [15:0] v);
        logic [31:0] dummy;
        bus(1'b1, IPR_OFS_PRIO, {16'hFFFF, v}, 4'hF, dummy);
    endtask : wr_prio

    // Reset contents of register and outputs
    task automatic t_reset;
        chk("levels", irq_levels, 32'h4444);
        chk("any", irq_any, 32'h0);
        bus(1'b0, IPR_OFS_PRIO, 32'h0, 4'hF, rd);
        chk("prio", rd, 32'h0000_4444);
        $display("test reset done");
    endtask : t_reset

    // Field read/write, reserved bits, byte lanes, unmapped space
    task automatic t_access;
        wr_prio(16'hFFFF);
        bus(1'b0, IPR_OFS_PRIO, 32'h0, 4'hF, rd);
        chk("prio", rd, 32'h0000_7777);
        wr_prio(16'h8888);
        bus(1'b0, IPR_OFS_PRIO, 32'h0, 4'hF, rd);
        chk("prio", rd, 32'h0);
        bus(1'b1, IPR_OFS_PRIO, 32'h0000_2536, 4'h1, rd);
        bus(1'b1, IPR_OFS_PRIO, 32'h0000_6121, 4'h2, rd);
        bus(1'b0, IPR_OFS_PRIO, 32'h0, 4'hF, rd);
        chk("prio", rd, 32'h0000_6136);
        chk("levels", irq_levels, 32'h6136);
        bus(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF, rd);
        bus(1'b1, IPR_OFS_STAT, 32'hFFFF_FFFF, 4'hF, rd);
        bus(1'b1, IPR_OFS_PRIO, 32'hFFFF_FFFF, 4'hC, rd);
        bus(1'b0, 4'hC, 32'h0, 4'hF, rd);
        chk("unmapped", rd, 32'h0);
        bus(1'b0, IPR_OFS_PRIO, 32'h0, 4'hF, rd);
        chk("prio", rd, 32'h0000_6136);
        $display("test access done");
    endtask : t_access

    // Every level in every field, one source at a time
    task automatic t_levels;
        logic [15:0] v;
        logic [3:0]  pend;
        for (int s = 0; s < 4; s++) begin
            for (int l = 0; l < 8; l++) begin
                v = 16'(l) << (4 * s);
                pend = (l != 0) ? 4'(1 << s) : 4'h0;
                wr_prio(v);
                @(posedge mclk);
                src_irq <= 4'hF;
                repeat (3) @(posedge mclk);
                #1;
                chk("pending", irq_pending, pend);
                chk("top", irq_top_level, 32'(l));
                chk("any", irq_any, 32'(l != 0));
                bus(1'b0, IPR_OFS_STAT, 32'h0, 4'hF, rd);
                chk("status", rd, {25'h0, 3'(l), pend});
                src_irq <= 4'h0;
            end
        end
        $display("test levels done");
    endtask : t_levels

    // Highest enabled level wins; disabled sources never count
    task automatic t_order;
        wr_prio(16'h1357);
        @(posedge mclk);
        src_irq <= 4'b0110;
        repeat (3) @(posedge mclk);
        #1;
        chk("top", irq_top_level, 32'h5);
        wr_prio(16'h7077);
        @(posedge mclk);
        src_irq <= 4'b0100;
        repeat (3) @(posedge mclk);
        #1;
        chk("pending", irq_pending, 32'h0);
        chk("any", irq_any, 32'h0);
        @(posedge mclk);
        src_irq <= 4'b1100;
        repeat (3) @(posedge mclk);
        #1;
        chk("top", irq_top_level, 32'h7);
        wr_prio(16'h0062);
        @(posedge mclk);
        src_irq <= 4'b0011;
        repeat (3) @(posedge mclk);
        #1;
        chk("top", irq_top_level, 32'h6);
        $display("test order done");
    endtask : t_order

    // Clock enable low freezes state and stretches a held access
    task automatic t_freeze;
        @(posedge mclk);
        src_irq <= 4'h0;
        wr_prio(16'h0007);
        @(posedge mclk);
        clk_en  <= 1'b0;
        src_irq <= 4'h1;
        repeat (3) @(posedge mclk);
        #1;
        chk("frozen pending", irq_pending, 32'h0);
        chk("frozen levels", irq_levels, 32'h0007);
        fork
            bus(1'b1, IPR_OFS_PRIO, 32'h0000_0005, 4'hF, rd);
            begin
                repeat (4) @(posedge mclk);
                clk_en <= 1'b1;
            end
        join
        repeat (3) @(posedge mclk);
        #1;
        chk("pending", irq_pending, 32'h1);
        chk("top", irq_top_level, 32'h5);
        bus(1'b0, IPR_OFS_PRIO, 32'h0, 4'hF, rd);
        chk("prio", rd, 32'h0000_0005);
        $display("test freeze done");
    endtask : t_freeze

    // Watchdog: far beyond the expected run length
    initial begin
        #(25 * 20000);
        errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset();
        t_access();
        t_levels();
        t_order();
        t_freeze();
        complete_run();
    end
endmodule : tb_top
